// ---- bench/tb_top.sv ----
// Self-checking bench for the answer status monitor.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import wrms_pkg::*;
   logic aclk = 0, aresetn = 0, clk_en = 1;
   logic [11:0] s_awaddr = 0, s_araddr = 0;
   logic [31:0] s_wdata = 0, s_rdata;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic byte_valid, byte_correct, answer_done, error_count_pulse;
   logic window_open = 1, window_end = 0, run_end = 0, reset_event = 0, abort_event = 0;
   logic go = 0;
   logic [2:0] nbytes = 3'h4, bad_idx = 3'h4;
   int mismatches = 0, samples_checked = 0, cycles = 0, done_n = 0, err_n = 0;
   logic [31:0] d;
   logic [1:0] r;
   wrms_top dut (.aclk, .aresetn, .clk_en, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .byte_valid, .byte_correct, .window_open, .window_end, .run_end, .reset_event,
      .abort_event, .answer_done, .error_count_pulse);
   wrms_mcu_model mcu (.aclk, .go, .nbytes, .bad_idx, .byte_valid, .byte_correct);
   always #4 aclk = ~aclk;
   // Pulse counters and the hang limit.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (answer_done === 1'b1) done_n <= done_n + 1;
      if (error_count_pulse === 1'b1) err_n <= err_n + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   // Write with both halves offered together; each is released once taken.
   task automatic axw(input logic [11:0] a, input logic [31:0] v);
      logic aw, w, b;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1;
      s_wvalid <= 1;
      s_bready <= 1;
      forever begin
         @(negedge aclk);
         aw = s_awvalid & s_awready;
         w = s_wvalid & s_wready;
         b = s_bvalid;
         r = s_bresp;
         @(posedge aclk);
         if (aw) s_awvalid <= 0;
         if (w) s_wvalid <= 0;
         if (b) begin
            s_bready <= 0;
            break;
         end
      end
   endtask
   task automatic axr(input logic [11:0] a);
      logic ar, rv;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1;
      s_rready <= 1;
      forever begin
         @(negedge aclk);
         ar = s_arvalid & s_arready;
         rv = s_rvalid;
         d = s_rdata;
         r = s_rresp;
         @(posedge aclk);
         if (ar) s_arvalid <= 0;
         if (rv) begin
            s_rready <= 0;
            break;
         end
      end
   endtask
   task automatic ans(input logic [2:0] n, input logic [2:0] bad);
      @(posedge aclk);
      nbytes <= n;
      bad_idx <= bad;
      go <= 1;
      @(posedge aclk);
      go <= 0;
      repeat (12) @(posedge aclk);
   endtask
   task automatic pulse_run_end();
      @(posedge aclk);
      run_end <= 1;
      @(posedge aclk);
      run_end <= 0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic t_reset();
      axr(WRMS_OFF_STATUS);
      chk(d, 32'hd0, "status reset");
      axr(WRMS_OFF_COUNTERS);
      chk(d, 32'h00, "counters reset");
      axw(WRMS_OFF_COUNTERS, 32'hff);
      chk(r, WRMS_RESP_SLVERR, "read-only write");
      axr(12'h020);
      chk(r, WRMS_RESP_DECERR, "unmapped read");
   endtask
   task automatic t_steps();
      int n;
      for (n = 1; n < 4; n++) begin
         ans(n[2:0], 3'h4);
         axr(WRMS_OFF_STATUS);
         chk(d[WRMS_CNT_HI:WRMS_CNT_LO], 2'h3 - n[1:0], "byte counter");
         pulse_run_end();
      end
      chk(done_n, 0, "no early completion");
   endtask
   task automatic t_good();
      ans(3'h4, 3'h4);
      chk(done_n, 1, "answer complete");
      chk(err_n, 1, "zero window error");
      axr(WRMS_OFF_STATUS);
      chk(d[7:0] & 8'hf7, 8'hd0, "status after good");
   endtask
   task automatic t_error();
      ans(3'h4, 3'h2);
      chk(err_n, 1, "no zero-window count with bad byte");
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_CURRENT], 1, "current error held");
      chk(d[WRMS_BIT_PREVIOUS], 0, "previous clear");
      pulse_run_end();
      axr(WRMS_OFF_STATUS);
      chk({d[WRMS_BIT_CURRENT], d[WRMS_BIT_PREVIOUS]}, 2'b01, "error moved");
      pulse_run_end();
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_PREVIOUS], 0, "clean run");
   endtask
   task automatic pulse_window_end();
      @(posedge aclk);
      window_end <= 1;
      @(posedge aclk);
      window_end <= 0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic t_missing();
      pulse_run_end();
      pulse_window_end();
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_MISSING], 1, "missing set");
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_MISSING], 0, "missing cleared by read");
      // The window closes again with no answer, so the late answer must replace a raised missing flag.
      pulse_window_end();
      window_open <= 0;
      ans(3'h4, 3'h4);
      chk(err_n, 1, "no count outside window");
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_PREMATURE], 1, "late answer premature");
      chk(d[WRMS_BIT_MISSING], 0, "premature replaces missing");
      pulse_run_end();
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_PREMATURE], 0, "premature cleared");
      window_open <= 1;
   endtask
   task automatic t_setting();
      axw(WRMS_OFF_CONTROL, 32'h05);
      chk(r, WRMS_RESP_OKAY, "setting write");
      axr(WRMS_OFF_CONTROL);
      chk(d, 32'h05, "setting readback");
      axr(WRMS_OFF_STATUS);
      chk(d[WRMS_BIT_ZERO], 0, "zero flag off");
      ans(3'h4, 3'h4);
      chk(err_n, 1, "no count with nonzero window");
   endtask
   task automatic t_counters();
      repeat (2) begin
         @(posedge aclk) reset_event <= 1;
         @(posedge aclk) reset_event <= 0;
      end
      repeat (9) begin
         @(posedge aclk) abort_event <= 1;
         @(posedge aclk) abort_event <= 0;
      end
      repeat (2) @(posedge aclk);
      // Events seen while the clock enable is low must not count.
      clk_en <= 0;
      repeat (2) begin
         @(posedge aclk) reset_event <= 1;
         @(posedge aclk) reset_event <= 0;
      end
      clk_en <= 1;
      repeat (2) @(posedge aclk);
      axr(WRMS_OFF_COUNTERS);
      chk(d, 32'h3a, "event counters saturate and freeze");
   endtask
   // A second reset in mid-run must bring every register back to its reset image.
   task automatic t_uv_reset();
      @(posedge aclk);
      aresetn <= 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      axr(WRMS_OFF_COUNTERS);
      chk(d, 32'h00, "counters after reset");
      axr(WRMS_OFF_STATUS);
      chk(d, 32'hd0, "status after reset");
      axr(WRMS_OFF_CONTROL);
      chk(d, 32'h00, "setting after reset");
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      t_reset();
      t_steps();
      t_good();
      t_error();
      t_missing();
      t_setting();
      t_counters();
      t_uv_reset();
      end_of_test();
   end
endmodule
`default_nettype wire

// ---- bench/wrms_mcu_model.sv ----
// Controller model that returns answer bytes to the status monitor.
`timescale 1ns/1ns
`default_nettype none
module wrms_mcu_model (
   input wire logic aclk,
   input wire logic go,
   input wire logic [2:0] nbytes,
   input wire logic [2:0] bad_idx,
   output logic byte_valid,
   output logic byte_correct
);
   logic [3:0] step;
   logic busy;
   initial begin
      byte_valid = 1'b0;
      byte_correct = 1'b0;
      busy = 1'b0;
      step = 4'h0;
   end
   // bytes from three downward, nbytes in all, one idle cycle between bytes.
   always @(posedge aclk) begin
      byte_valid <= busy && step[0];
      // Between bytes the qualifier toggles so a stale level is never trusted.
      byte_correct <= (busy && step[0]) ? ({1'b0, 2'h3 - step[2:1]} != bad_idx) : !byte_correct;
      if (go && !busy) begin
         busy <= 1'b1;
         step <= 4'h0;
      end else if (busy) begin
         step <= step + 4'h1;
         if (step == {nbytes, 1'b0} - 4'h1) busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/wrms_axil.sv ----
// AXI4-Lite slave with a single write and a single read slot.
`timescale 1ns/1ns
`default_nettype none
module wrms_axil
   import wrms_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic wr_pulse,
   output logic [11:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic [1:0] wr_resp,
   output logic rd_pulse,
   output logic [11:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic [1:0] rd_resp
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } wrms_axil_t;
   wrms_axil_t st, next_st;

   // Handshake readiness is derived straight from the slot state.
   assign s_awready = !st.aw_got && !st.bvalid;
   assign s_wready = !st.w_got && !st.bvalid;
   assign s_arready = !st.rvalid;
   assign s_bvalid = st.bvalid;
   assign s_bresp = st.bresp;
   assign s_rvalid = st.rvalid;
   assign s_rdata = st.rdata;
   assign s_rresp = st.rresp;
   assign wr_pulse = clk_en && st.aw_got && st.w_got && !st.bvalid;
   assign wr_addr = st.awaddr;
   assign wr_data = st.wdata;
   assign wr_strb = st.wstrb;
   assign rd_pulse = clk_en && s_arvalid && s_arready;
   assign rd_addr = s_araddr;

   // Address and data are taken in either order; the response follows both.
   always_comb begin
      next_st = st;
      if (s_awvalid && s_awready) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_wdata;
         next_st.wstrb = s_wstrb;
      end
      if (wr_pulse) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = wr_resp;
      end
      if (st.bvalid && s_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (rd_pulse) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_data;
         next_st.rresp = rd_resp;
      end else if (st.rvalid && s_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/wrms_pkg.sv ----
// Package with register map, field layout and state encoding for the answer status monitor.
package wrms_pkg;
   localparam logic [11:0] WRMS_OFF_STATUS = 12'h00c;
   localparam logic [11:0] WRMS_OFF_COUNTERS = 12'h010;
   localparam logic [11:0] WRMS_OFF_CONTROL = 12'h014;
   localparam logic [7:0] WRMS_STATUS_RESET = 8'hc0;
   localparam logic [7:0] WRMS_COUNTERS_RESET = 8'h00;
   localparam logic [1:0] WRMS_CNT_FIRST = 2'h3;
   localparam logic [1:0] WRMS_CNT_LAST = 2'h0;
   localparam logic [1:0] WRMS_RESP_OKAY = 2'h0;
   localparam logic [1:0] WRMS_RESP_SLVERR = 2'h2;
   localparam logic [1:0] WRMS_RESP_DECERR = 2'h3;
   localparam int WRMS_BIT_PREMATURE = 0;
   localparam int WRMS_BIT_MISSING = 1;
   localparam int WRMS_BIT_PREVIOUS = 2;
   localparam int WRMS_BIT_ZERO = 4;
   localparam int WRMS_BIT_CURRENT = 5;
   localparam int WRMS_CNT_LO = 6;
   localparam int WRMS_CNT_HI = 7;
   localparam int WRMS_RST_LO = 0;
   localparam int WRMS_RST_HI = 2;
   localparam int WRMS_AB_LO = 3;
   localparam int WRMS_AB_HI = 5;
   localparam logic [2:0] WRMS_CNT_ONE = 3'h1;
   localparam logic [2:0] WRMS_CNT_MAX = 3'h7;
   typedef enum logic [1:0] {
      WRMS_IDLE = 2'h0,
      WRMS_WDATA = 2'h1,
      WRMS_RESP = 2'h3
   } wrms_wr_t;
endpackage

// ---- rtl/wrms_top.sv ----
// Answer status monitor of the question-and-answer watchdog, with AXI4-Lite registers.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module wrms_top
   import wrms_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic byte_valid,
   input wire logic byte_correct,
   input wire logic window_open,
   input wire logic window_end,
   input wire logic run_end,
   input wire logic reset_event,
   input wire logic abort_event,
   output logic answer_done,
   output logic error_count_pulse
);
   typedef struct packed {
      logic [1:0] answer_byte_counter;
      logic current_run_error;
      logic previous_run_error;
      logic missing_answer_flag;
      logic premature_answer_flag;
      logic zero_window_flag;
      logic answer_seen;
      logic answer_done;
      logic error_count_pulse;
      logic [7:0] answer_window_setting;
      logic [2:0] reset_event_counter;
      logic [2:0] abort_event_counter;
   } wrms_top_t;
   wrms_top_t st, next_st;

   logic wr_pulse, rd_pulse;
   logic [11:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [1:0] wr_resp, rd_resp;
   logic [7:0] status_byte, counter_byte;
   logic final_byte;

   // Saturating three-bit event counter step.
   function automatic logic [2:0] wrms_sat_inc(input logic [2:0] v);
      wrms_sat_inc = (v == WRMS_CNT_MAX) ? v : 3'(v + WRMS_CNT_ONE);
   endfunction

   wrms_axil u_axil (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
      .wr_resp(wr_resp), .rd_pulse(rd_pulse), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_resp(rd_resp)
   );

   // Register images as software sees them.
   always_comb begin
      status_byte = '0;
      status_byte[WRMS_CNT_HI:WRMS_CNT_LO] = st.answer_byte_counter;
      status_byte[WRMS_BIT_CURRENT] = st.current_run_error;
      status_byte[WRMS_BIT_ZERO] = st.zero_window_flag;
      status_byte[WRMS_BIT_PREVIOUS] = st.previous_run_error;
      status_byte[WRMS_BIT_MISSING] = st.missing_answer_flag;
      status_byte[WRMS_BIT_PREMATURE] = st.premature_answer_flag;
      counter_byte = '0;
      counter_byte[WRMS_RST_HI:WRMS_RST_LO] = st.reset_event_counter;
      counter_byte[WRMS_AB_HI:WRMS_AB_LO] = st.abort_event_counter;
   end

   // Read decode; unmapped addresses answer with a decode error.
   always_comb begin
      rd_data = '0;
      rd_resp = WRMS_RESP_OKAY;
      case (rd_addr)
         WRMS_OFF_STATUS: rd_data[7:0] = status_byte;
         WRMS_OFF_COUNTERS: rd_data[7:0] = counter_byte;
         WRMS_OFF_CONTROL: rd_data[7:0] = st.answer_window_setting;
         default: rd_resp = WRMS_RESP_DECERR;
      endcase
   end

   // Only the window setting is writable; read-only registers refuse writes.
   always_comb begin
      case (wr_addr)
         WRMS_OFF_CONTROL: wr_resp = WRMS_RESP_OKAY;
         WRMS_OFF_STATUS: wr_resp = WRMS_RESP_SLVERR;
         WRMS_OFF_COUNTERS: wr_resp = WRMS_RESP_SLVERR;
         default: wr_resp = WRMS_RESP_DECERR;
      endcase
   end

   assign final_byte = byte_valid && (st.answer_byte_counter == WRMS_CNT_LAST);
   assign answer_done = st.answer_done;
   assign error_count_pulse = st.error_count_pulse;

   // Answer tracking, run bookkeeping and flag updates.
   always_comb begin
      next_st = st;
      next_st.answer_done = 1'b0;
      next_st.error_count_pulse = 1'b0;
      if (wr_pulse && wr_addr == WRMS_OFF_CONTROL && wr_strb[0]) begin
         next_st.answer_window_setting = wr_data[7:0];
      end
      next_st.zero_window_flag = (next_st.answer_window_setting == '0);
      if (byte_valid) begin
         next_st.answer_byte_counter = 2'(st.answer_byte_counter - 2'h1);
      end
      if (final_byte) begin
         next_st.answer_done = 1'b1;
         next_st.answer_seen = 1'b1;
         if (!window_open) begin
            next_st.premature_answer_flag = 1'b1;
            next_st.missing_answer_flag = 1'b0;
         end
         if (st.zero_window_flag && window_open && byte_correct && !st.current_run_error) begin
            next_st.error_count_pulse = 1'b1;
         end
      end
      // Missing flag clears on a status read.
      if (rd_pulse && rd_addr == WRMS_OFF_STATUS) begin
         next_st.missing_answer_flag = 1'b0;
      end
      if (window_end && !st.answer_seen && !final_byte) begin
         next_st.missing_answer_flag = 1'b1;
      end
      if (run_end) begin
         next_st.previous_run_error = st.current_run_error;
         next_st.current_run_error = 1'b0;
         // A late answer landing on the run end still sets the flag, so the set wins over the clear.
         next_st.premature_answer_flag = final_byte && !window_open;
         next_st.answer_seen = 1'b0;
         next_st.answer_byte_counter = WRMS_CNT_FIRST;
      end
      if (byte_valid && !byte_correct) begin
         next_st.current_run_error = 1'b1;
      end
      if (reset_event) begin
         next_st.reset_event_counter = wrms_sat_inc(st.reset_event_counter);
      end
      if (abort_event) begin
         next_st.abort_event_counter = wrms_sat_inc(st.abort_event_counter);
      end
   end

   // State register; reset models the undervoltage reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.answer_byte_counter <= WRMS_CNT_FIRST;
         st.zero_window_flag <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   AST_ERR_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && st.current_run_error && !run_end |=> st.current_run_error)
      else $error("current run error dropped inside a run");
   AST_RUN_TRANSFER: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && run_end && !(byte_valid && !byte_correct) |=>
      st.previous_run_error == $past(st.current_run_error) && !st.current_run_error)
      else $error("run end did not move error to previous");
   AST_PREV_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && !run_end |=> $stable(st.previous_run_error))
      else $error("previous run error changed outside run end");
   AST_CNT_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && byte_valid && !run_end |=> st.answer_byte_counter == 2'($past(st.answer_byte_counter) - 2'h1))
      else $error("answer byte counter did not step down");
   AST_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && byte_valid && st.answer_byte_counter == WRMS_CNT_LAST |=> answer_done)
      else $error("answer not marked complete after final byte");
   AST_MISSING: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && window_end && !st.answer_seen && !final_byte |=> st.missing_answer_flag)
      else $error("missing answer flag not raised");
   AST_PREMATURE: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && final_byte && !window_open && !run_end && !window_end |=>
      st.premature_answer_flag && !st.missing_answer_flag)
      else $error("premature answer did not replace missing");
   AST_NO_FALSE_MISSING: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && !st.missing_answer_flag && (!window_end || st.answer_seen) |=> !st.missing_answer_flag)
      else $error("missing flag raised without window end");
   AST_ERR_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && byte_valid && !byte_correct |=> st.current_run_error)
      else $error("wrong byte did not set current run error");
   AST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> st.zero_window_flag == (st.answer_window_setting == 8'h00))
      else $error("zero window flag wrong");
   COV_ANSWER: cover property (@(posedge aclk) disable iff (!aresetn) answer_done);
   COV_MISSING: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st.missing_answer_flag));
   COV_PREV: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st.previous_run_error));
   COV_ZERO_COUNT: cover property (@(posedge aclk) disable iff (!aresetn) error_count_pulse);
endmodule
`default_nettype wire
